// ### bench/blit_engine_tb.sv
// self-checking bench for blit_engine, host side over ahb-lite
// assumes a single slave and the combinational memory model
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
module blit_engine_tb;
  import blit_pkg::*;
  // ----
  // signals
  // ----
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, step, busy, fault, chk, b;
  logic [31:0] hrdata, sp, pp, dp, wa, rd;
  logic [31:0] mx = 32'h4000_0001;
  logic [7:0] ms, mp, md, res;
  logic [39:0] eq[$];
  logic [39:0] e;
  int err_total = 0;
  int cmp_count = 0;

  blit_mem_model i_mem (.src_a_i(sp), .pat_a_i(pp), .dst_a_i(dp),
    .src_o(ms), .pat_o(mp), .dst_o(md));
  blit_engine i_dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout),
    .hrdata_o(hrdata), .hresp_o(hresp), .mem_src_i(ms), .mem_pat_i(mp),
    .mem_dst_i(md), .src_ptr_o(sp), .pat_ptr_o(pp), .dst_ptr_o(dp),
    .step_o(step), .wr_addr_o(wa), .result_o(res), .busy_o(busy), .fault_o(fault));

  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ----
  // tasks
  // ----
  task automatic fail(input string m);
    err_total++;
    $display("ERROR %0t: %s", $time, m);
  endtask : fail
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hreadyout !== 1'b1 && n < 500);
    if (n >= 500) fail("bus hang");
  endtask : wait_rdy
  // one single word transfer; read data taken at the closing edge
  task automatic xfer(input logic w, input logic [3:0] i, input logic [31:0] d);
    haddr <= {26'h0, i, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : xfer
  task automatic rchk(input logic [3:0] i, input logic [31:0] x);
    xfer(1'b0, i, 32'h0);
    `CHK(rd, x)
    `CHK(hresp, 1'b0)
  endtask : rchk
  task automatic go(input logic [31:0] rt, input logic [31:0] ct, input logic [31:0] rp,
                    input logic [31:0] xc, input logic [31:0] yc, input logic [31:0] op);
    xfer(1'b1, IDX_ROUTE, rt);
    xfer(1'b1, IDX_CTRL, ct);
    xfer(1'b1, IDX_ROP, rp);
    xfer(1'b1, IDX_HORIZONTAL_COUNT, xc);
    xfer(1'b1, IDX_VERTICAL_COUNT, yc);
    xfer(1'b1, IDX_OPST, op);
  endtask : go
  // memory-route walk from source 100, destination 200
  task automatic exp_walk(input int xc, input int yc);
    logic [31:0] s;
    for (int y = 0; y <= yc; y++) begin
      for (int x = 0; x <= xc; x++) begin
        s = 32'h100 + y * 32'h40 + x;
        eq.push_back({s[7:0] + 8'h11, 32'h200 + y * 32'h20 + x});
      end
    end
  endtask : exp_walk
  // polls busy; short settle first so the launching edge has landed
  task automatic wait_idle(input string t);
    int n;
    n = 0;
    repeat (2) @(posedge clk_i);
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) fail("op hang");
    repeat (3) @(posedge clk_i);
    `CHK(eq.size(), 0)
    $display("test %s done", t);
  endtask : wait_idle
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  always @(posedge clk_i) begin
    if (step === 1'b1 && chk === 1'b1) begin
      if (eq.size() == 0) begin
        fail("extra step");
      end else begin
        e = eq.pop_front();
        `CHK(res, e[39:32])
        `CHK(wa, e[31:0])
      end
    end
  end
  // ----
  // watchdog: all tests need well under 5000 cycles
  // ----
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
  // ----
  // sequence
  // ----
  initial begin
    chk = 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    xfer(1'b0, IDX_STAT, 32'h0);
    `CHK(rd[2:0], 3'b010)
    xfer(1'b1, IDX_SRC, 32'h100);
    xfer(1'b1, IDX_PAT, 32'h300);
    xfer(1'b1, IDX_DST, 32'h200);
    rchk(IDX_SRC, 32'h0);
    xfer(1'b1, IDX_OPST, 32'h1);
    rchk(IDX_DST, 32'h200);
    rchk(IDX_SRC, 32'h0);
    xfer(1'b1, IDX_OPST, 32'h1);
    rchk(IDX_SRC, 32'h100);
    rchk(IDX_DST, 32'h200);
    $display("test queue done");
    xfer(1'b1, IDX_SOFF, 32'h40);
    xfer(1'b1, IDX_DOFF, 32'h20);
    xfer(1'b1, IDX_XPOS, 32'h0);
    xfer(1'b1, IDX_YPOS, 32'h0);
    exp_walk(3, 1);
    go(32'h0, 32'h0, 32'h00CC, 3, 1, 32'h9);
    wait_idle("memory walk");
    rchk(IDX_SRC, 32'h180);
    rchk(IDX_PAT, 32'h300);
    eq.push_back({8'h91, 32'h200});
    go(32'h0, 32'h1000, 32'h00CC, 0, 0, 32'h9);
    wait_idle("reload");
    rchk(IDX_SRC, 32'h1C0);
    for (int i = 1; i <= 11; i++) begin
      eq.push_back({i[7:0], 32'h1FF + i});
    end
    go(32'h1, 32'h12, 32'h00CC, 10, 0, 32'h9);
    xfer(1'b1, IDX_DATA, 32'h0403_0201);
    xfer(1'b1, IDX_DATA, 32'h0807_0605);
    xfer(1'b1, IDX_DATA, 32'h0C0B_0A09);
    wait_idle("host source");
    rchk(IDX_SRC, 32'h100);
    `CHK(fault, 1'b0)
    for (int xd = 0; xd < 2; xd++) begin
      for (int i = 0; i < 8; i++) begin
        b = xd ? mx[31 - i] : mx[i];
        eq.push_back({{8{b}}, xd ? 32'h203 - i : 32'h200 + i});
      end
      go(32'h2, {23'h0, xd[0], 8'h02}, 32'h00FF, 7, 0, 32'h9);
      xfer(1'b1, IDX_DATA, mx);
      wait_idle("mix");
    end
    exp_walk(2, 0);
    go(32'h4, 32'h0, 32'h00CC, 1, 0, 32'h1);
    xfer(1'b1, IDX_DATA, 32'h2);
    wait_idle("count x");
    exp_walk(1, 1);
    go(32'h5, 32'h0, 32'h00CC, 1, 0, 32'h1);
    xfer(1'b1, IDX_DATA, 32'h1);
    wait_idle("count y");
    exp_walk(2, 0);
    go(32'h10, 32'h0, 32'h00CC, 2, 0, 32'h9);
    repeat (3) xfer(1'b1, IDX_DATA, 32'h0);
    wait_idle("host steps");
    // overrun with wait states off: results no longer tracked
    chk = 1'b0;
    go(32'h1, 32'h2, 32'h00CC, 15, 0, 32'h9);
    repeat (4) xfer(1'b1, IDX_DATA, 32'h0);
    xfer(1'b0, IDX_STAT, 32'h0);
    `CHK(rd[2], 1'b1)
    `CHK(fault, 1'b1)
    xfer(1'b1, IDX_STAT, 32'h4);
    @(posedge clk_i);
    `CHK(fault, 1'b0)
    $display("test fault done");
    wrap_up();
  end
endmodule : blit_engine_tb

// ### bench/blit_mem_model.sv
// display memory stand-in: one byte per pointer, a pattern of the address
// assumes the pointers are registered levels from the engine
`timescale 1ns/1ps
module blit_mem_model (
  // pointers
  input wire logic [31:0] src_a_i,
  input wire logic [31:0] pat_a_i,
  input wire logic [31:0] dst_a_i,
  // bytes at those pointers
  output logic [7:0] src_o,
  output logic [7:0] pat_o,
  output logic [7:0] dst_o
);
  // distinct per map so a byte fetched from the wrong map shows
  assign src_o = src_a_i[7:0] + 8'h11;
  assign pat_o = pat_a_i[7:0] ^ 8'hA5;
  assign dst_o = ~dst_a_i[7:0];
endmodule : blit_mem_model

// ### pkg/blit_pkg.sv
// constants shared by the block-transfer queue, engine and host feed
// assumes a single core clock and an AHB-Lite register port
package blit_pkg;

  // ----------------------------------------------------------------
  // register word indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam int NREG = 13;
  localparam logic [3:0] IDX_SRC = 4'h0;
  localparam logic [3:0] IDX_PAT = 4'h1;
  localparam logic [3:0] IDX_DST = 4'h2;
  localparam logic [3:0] IDX_SOFF = 4'h3;
  localparam logic [3:0] IDX_POFF = 4'h4;
  localparam logic [3:0] IDX_DOFF = 4'h5;
  localparam logic [3:0] IDX_HORIZONTAL_COUNT = 4'h6;
  localparam logic [3:0] IDX_VERTICAL_COUNT = 4'h7;
  localparam logic [3:0] IDX_XPOS = 4'h8;
  localparam logic [3:0] IDX_YPOS = 4'h9;
  localparam logic [3:0] IDX_ROP = 4'hA;
  localparam logic [3:0] IDX_ROUTE = 4'hB;
  localparam logic [3:0] IDX_CTRL = 4'hC;
  localparam logic [3:0] IDX_OPST = 4'hD;
  localparam logic [3:0] IDX_STAT = 4'hE;
  localparam logic [3:0] IDX_DATA = 4'hF;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int OP_RESTORE_BIT = 0;
  localparam int OP_RESUME_BIT = 3;
  localparam int CTRL_SYNC_BIT = 4;
  localparam int CTRL_XDEC_BIT = 8;
  localparam int CTRL_YDEC_BIT = 9;
  localparam int CTRL_RLD_SRC_BIT = 12;
  localparam int CTRL_RLD_PAT_BIT = 13;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WRST_BIT = 1;
  localparam int STAT_FAULT_BIT = 2;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // routing and width encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDRESS_ROUTE_FIELD_BLT = 2'h0;
  localparam logic [1:0] ADDRESS_ROUTE_FIELD_HOST = 2'h1;
  localparam logic [2:0] DATA_ROUTE_FIELD_MEM = 3'h0;
  localparam logic [2:0] DATA_ROUTE_FIELD_SRC = 3'h1;
  localparam logic [2:0] DATA_ROUTE_FIELD_MIX = 3'h2;
  localparam logic [2:0] DATA_ROUTE_FIELD_HORIZONTAL_COUNT = 3'h4;
  localparam logic [2:0] DATA_ROUTE_FIELD_VERTICAL_COUNT = 3'h5;

  function automatic logic [2:0] width_bytes(input logic [1:0] enc);
    case (enc)
      2'h0: width_bytes = 3'h1;
      2'h1: width_bytes = 3'h2;
      default: width_bytes = 3'h4;
    endcase
  endfunction : width_bytes

endpackage : blit_pkg

// ### src/blit_engine.sv
// block-transfer queue, working set, address walker and AHB-Lite port
// assumes display memory bytes at the three pointer outputs are valid
`timescale 1ns/1ps

// Overview of operation
// [RL1] queued values survive every restore transfer
// [RL2] register reads show only internal state
// [RL3] restore bit moves queue into internal
// [RL4] host restores only while engine idle; the code also restores while the engine is busy
// [RL5] source, pattern three stages; others two
// [RL6] internal pointers step through memory
// [RL7] reload bits keep current source, pattern
// [RL8] finished pointers sit on next line
// [RL9] internal X, Y positions track progress
// [RL10] step map only when raster op uses
// [RL11] engine walks; route picks data origin
// [RL12] host paces each step in route 01
// [RL13] byte write loads count and starts
// [RL14] per byte three-input op chosen by mix
// [RL15] mix never read from display memory
// [RL16] gather transfer width before releasing data
// [RL17] accumulation only for host source, mix
// [RL18] host aligns word and double writes
// [RL19] surplus host bytes dropped at line end
// [RL20] decreasing start derived from last element
// [RL21] sync on: wait states while full
// [RL22] mix bit order follows X direction
// [RL23] sync off: full write dropped, faulted
// [RL24] walk line by count, add offsets
// [RL25] write status shows room for data
module blit_engine
  import blit_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic [31:0] hrdata_o,
  output logic hresp_o,
  // display memory
  input wire logic [7:0] mem_src_i,
  input wire logic [7:0] mem_pat_i,
  input wire logic [7:0] mem_dst_i,
  output logic [31:0] src_ptr_o,
  output logic [31:0] pat_ptr_o,
  output logic [31:0] dst_ptr_o,
  output logic step_o,
  output logic [31:0] wr_addr_o,
  output logic [7:0] result_o,
  // status
  output logic busy_o,
  output logic fault_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic rop_uses(input logic [7:0] r, input int b);
    rop_uses = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (r[i] != r[i ^ (1 << b)]) begin
        rop_uses = 1'b1;
      end
    end
  endfunction : rop_uses

  function automatic logic [7:0] rop_apply(input logic [7:0] r, input logic [7:0] sv,
                                           input logic [7:0] pv, input logic [7:0] dv);
    for (int j = 0; j < 8; j++) begin
      rop_apply[j] = r[{pv[j], sv[j], dv[j]}];
    end
  endfunction : rop_apply

  function automatic logic [31:0] advance(input logic [31:0] a, input logic xdec,
                                          input logic ydec, input logic lend,
                                          input logic [31:0] off, input logic [11:0] xc);
    logic [31:0] b;
    b = xdec ? a - 32'h1 : a + 32'h1;
    if (lend) begin
      // next line starts one offset beyond this line's first byte
      b = xdec ? a + {20'h0, xc} : a - {20'h0, xc};
      b = ydec ? b - off : b + off;
    end
    advance = b;
  endfunction : advance

  function automatic logic [3:0] lanes_of(input logic [2:0] sz, input logic [1:0] a);
    case (sz)
      3'h0: lanes_of = 4'h1 << a;
      3'h1: lanes_of = a[1] ? 4'hC : 4'h3;
      default: lanes_of = 4'hF;
    endcase
  endfunction : lanes_of

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NREG-1:0][31:0] q;
    logic [NREG-1:0][31:0] w;
    logic [31:0] init_src;
    logic [31:0] init_pat;
    logic [31:0] word;
    logic [31:0] hrdata;
    logic [31:0] wr_addr;
    logic [3:0] idx;
    logic [3:0] lanes;
    logic [1:0] alow;
    logic wpend;
    logic rpend;
    logic hready;
    logic hresp;
    logic fault;
    logic run;
    logic have_word;
    logic tok;
    logic step;
    logic [5:0] kidx;
    logic [7:0] result;
  } state_s;

  state_s s_reg;
  state_s s_next;
  logic feed_wr;
  logic feed_flush;
  logic feed_take;
  logic feed_in_ready;
  logic feed_valid;
  logic [31:0] feed_data;
  logic restore_now;
  logic drop_now;
  logic stall_now;
  logic stepping;
  logic lend;
  logic mix_bit;
  logic [31:0] rd_mux;

  blit_host_feed u_feed (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .wr_i(feed_wr),
    .lanes_i(s_reg.lanes),
    .wdata_i(hwdata_i),
    .width_i(s_reg.w[IDX_CTRL][1:0]),
    .flush_i(feed_flush),
    .in_ready_o(feed_in_ready),
    .out_valid_o(feed_valid),
    .out_data_o(feed_data),
    .out_ready_i(feed_take)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] data_route_field;
    logic [1:0] address_route_field;
    logic xdec;
    logic ydec;
    logic host_src;
    logic host_mix;
    logic need_word;
    logic unit_ok;
    logic yend;
    logic [7:0] sb;
    logic [7:0] rop;
    logic [5:0] nu;
    logic [5:0] bi;
    logic [2:0] nb;
    logic [2:0] qd;
    logic [2:0] nbq;
    logic [31:0] m;
    data_route_field = s_reg.w[IDX_ROUTE][2:0];
    address_route_field = s_reg.w[IDX_ROUTE][5:4];
    xdec = s_reg.w[IDX_CTRL][CTRL_XDEC_BIT];
    ydec = s_reg.w[IDX_CTRL][CTRL_YDEC_BIT];
    nb = width_bytes(s_reg.w[IDX_CTRL][1:0]);
    host_src = data_route_field == DATA_ROUTE_FIELD_SRC; // RL11
    host_mix = data_route_field == DATA_ROUTE_FIELD_MIX;
    need_word = host_src || host_mix; // RL17
    nu = host_mix ? {nb, 3'b000} : {3'b000, nb};
    qd = s_reg.q[IDX_ROUTE][2:0];
    nbq = width_bytes(s_reg.q[IDX_CTRL][1:0]);
    s_next = s_reg;
    s_next.step = 1'b0;
    s_next.hresp = 1'b0;
    feed_wr = 1'b0;
    feed_flush = 1'b0;
    restore_now = 1'b0;
    drop_now = 1'b0;
    stall_now = 1'b0;
    lend = s_reg.w[IDX_XPOS][11:0] == s_reg.w[IDX_HORIZONTAL_COUNT][11:0];
    yend = s_reg.w[IDX_YPOS][11:0] == s_reg.w[IDX_VERTICAL_COUNT][11:0];
    // host word pacing for host data routes, token pacing in route 01, free running otherwise
    unit_ok = need_word ? s_reg.have_word : (address_route_field == ADDRESS_ROUTE_FIELD_HOST ? s_reg.tok : 1'b1); // RL12
    stepping = s_reg.run && unit_ok;
    feed_take = s_reg.run && need_word && !s_reg.have_word && feed_valid;
    bi = xdec ? nu - 6'h1 - s_reg.kidx : s_reg.kidx; // RL22
    mix_bit = host_mix ? s_reg.word[bi[4:0]] : 1'b1; // RL15
    sb = host_src ? 8'(s_reg.word >> {s_reg.kidx[1:0], 3'b000}) : mem_src_i;
    rop = mix_bit ? s_reg.w[IDX_ROP][7:0] : s_reg.w[IDX_ROP][15:8];
    m = REG_RST;
    for (int j = 0; j < 4; j++) begin
      m[j * 8 +: 8] = {8{s_reg.lanes[j]}};
    end
    rd_mux = REG_RST;
    if (s_reg.idx < 4'(NREG)) begin
      rd_mux = s_reg.w[s_reg.idx]; // RL2
    end else if (s_reg.idx == IDX_STAT) begin
      rd_mux[STAT_BUSY_BIT] = s_reg.run;
      rd_mux[STAT_WRST_BIT] = need_word ? feed_in_ready : !s_reg.tok; // RL25
      rd_mux[STAT_FAULT_BIT] = s_reg.fault;
    end

    // --------------------------------------------------------------
    // engine walk
    // --------------------------------------------------------------
    if (feed_take) begin
      s_next.have_word = 1'b1;
      s_next.word = feed_data;
      s_next.kidx = 6'h0;
    end
    if (stepping) begin
      s_next.step = 1'b1;
      s_next.wr_addr = s_reg.w[IDX_DST];
      s_next.result = rop_apply(rop, sb, mem_pat_i, mem_dst_i); // RL14
      if (!host_src && (rop_uses(s_reg.w[IDX_ROP][7:0], 1) ||
                        rop_uses(s_reg.w[IDX_ROP][15:8], 1))) begin
        s_next.w[IDX_SRC] = advance(s_reg.w[IDX_SRC], xdec, ydec, lend,
                                    s_reg.w[IDX_SOFF], s_reg.w[IDX_HORIZONTAL_COUNT][11:0]); // RL10
      end
      if (rop_uses(s_reg.w[IDX_ROP][7:0], 2) || rop_uses(s_reg.w[IDX_ROP][15:8], 2)) begin
        s_next.w[IDX_PAT] = advance(s_reg.w[IDX_PAT], xdec, ydec, lend,
                                    s_reg.w[IDX_POFF], s_reg.w[IDX_HORIZONTAL_COUNT][11:0]); // RL6
      end
      s_next.w[IDX_DST] = advance(s_reg.w[IDX_DST], xdec, ydec, lend,
                                  s_reg.w[IDX_DOFF], s_reg.w[IDX_HORIZONTAL_COUNT][11:0]); // RL8
      s_next.w[IDX_XPOS] = lend ? REG_RST : {20'h0, s_reg.w[IDX_XPOS][11:0] + 12'h1}; // RL9
      if (lend) begin
        if (yend) begin
          s_next.run = 1'b0; // RL24
        end else begin
          s_next.w[IDX_YPOS] = {20'h0, s_reg.w[IDX_YPOS][11:0] + 12'h1};
        end
      end
      if (need_word) begin
        if (lend || s_reg.kidx == nu - 6'h1) begin
          s_next.have_word = 1'b0; // RL19
        end else begin
          s_next.kidx = s_reg.kidx + 6'h1;
        end
      end
      s_next.tok = 1'b0;
    end

    // --------------------------------------------------------------
    // bus: each transfer takes one wait state so data is settled, more while a synced full data write stalls
    // --------------------------------------------------------------
    if (hsel_i && htrans_i[1] && hready_i && s_reg.hready) begin
      s_next.idx = haddr_i[5:2];
      s_next.alow = haddr_i[1:0];
      s_next.lanes = lanes_of(hsize_i, haddr_i[1:0]);
      s_next.wpend = hwrite_i;
      s_next.rpend = !hwrite_i;
      s_next.hready = 1'b0;
    end
    if (s_reg.rpend) begin
      s_next.hrdata = rd_mux;
      s_next.rpend = 1'b0;
      s_next.hready = 1'b1;
    end
    if (s_reg.wpend) begin
      s_next.wpend = 1'b0;
      s_next.hready = 1'b1;
      if (s_reg.idx < 4'(NREG)) begin
        s_next.q[s_reg.idx] = (s_reg.q[s_reg.idx] & ~m) | (hwdata_i & m);
      end else if (s_reg.idx == IDX_OPST) begin
        if (hwdata_i[OP_RESTORE_BIT]) begin
          restore_now = 1'b1;
          for (int k = 0; k < NREG; k++) begin
            s_next.w[k] = s_reg.q[k]; // RL3
          end
          s_next.init_src = s_reg.q[IDX_SRC]; // RL5
          s_next.init_pat = s_reg.q[IDX_PAT];
          s_next.w[IDX_SRC] = s_reg.q[IDX_CTRL][CTRL_RLD_SRC_BIT] ?
                              s_reg.w[IDX_SRC] : s_reg.init_src; // RL7
          s_next.w[IDX_PAT] = s_reg.q[IDX_CTRL][CTRL_RLD_PAT_BIT] ?
                              s_reg.w[IDX_PAT] : s_reg.init_pat;
          if ((qd == DATA_ROUTE_FIELD_SRC || qd == DATA_ROUTE_FIELD_MIX) && s_reg.q[IDX_CTRL][CTRL_XDEC_BIT]) begin
            s_next.w[IDX_DST] = s_reg.q[IDX_DST] + 32'(nbq) - 32'h1; // RL20
          end
        end
        if (hwdata_i[OP_RESUME_BIT]) begin
          s_next.run = 1'b1;
          s_next.have_word = 1'b0;
          s_next.tok = 1'b0;
          feed_flush = 1'b1;
        end
      end else if (s_reg.idx == IDX_STAT) begin
        if (hwdata_i[STAT_FAULT_BIT]) begin
          s_next.fault = 1'b0;
        end
      end else if (s_reg.idx == IDX_DATA) begin
        if (data_route_field == DATA_ROUTE_FIELD_HORIZONTAL_COUNT || data_route_field == DATA_ROUTE_FIELD_VERTICAL_COUNT) begin
          if (data_route_field == DATA_ROUTE_FIELD_HORIZONTAL_COUNT) begin
            s_next.w[IDX_HORIZONTAL_COUNT][7:0] = 8'(hwdata_i >> {s_reg.alow, 3'b000}); // RL13
          end else begin
            s_next.w[IDX_VERTICAL_COUNT][7:0] = 8'(hwdata_i >> {s_reg.alow, 3'b000});
          end
          s_next.w[IDX_XPOS] = REG_RST;
          s_next.w[IDX_YPOS] = REG_RST;
          s_next.run = 1'b1;
        end else if ((need_word && !feed_in_ready) ||
                     (!need_word && s_reg.tok && !stepping)) begin
          if (s_reg.w[IDX_CTRL][CTRL_SYNC_BIT]) begin
            stall_now = 1'b1; // RL21
            s_next.wpend = 1'b1;
            s_next.hready = 1'b0;
          end else begin
            drop_now = 1'b1; // RL23
          end
        end else if (need_word) begin
          feed_wr = 1'b1; // RL16
        end else if (address_route_field == ADDRESS_ROUTE_FIELD_HOST && s_reg.run) begin
          s_next.tok = 1'b1; // RL12
        end
      end
    end
    if (drop_now) begin
      s_next.fault = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_reg <= '0;
      s_reg.hready <= 1'b1;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout_o = s_reg.hready;
  assign hrdata_o = s_reg.hrdata;
  assign hresp_o = s_reg.hresp;
  assign src_ptr_o = s_reg.w[IDX_SRC];
  assign pat_ptr_o = s_reg.w[IDX_PAT];
  assign dst_ptr_o = s_reg.w[IDX_DST];
  assign step_o = s_reg.step;
  assign wr_addr_o = s_reg.wr_addr;
  assign result_o = s_reg.result;
  assign busy_o = s_reg.run;
  assign fault_o = s_reg.fault;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i || !ce_i);

  a_queue_kept: assert property (restore_now |=> s_reg.q == $past(s_reg.q)) // RL1
    else $error("queue changed by restore");
  a_read_internal: assert property (s_reg.rpend |=> hrdata_o == $past(rd_mux) && hreadyout_o) // RL2
    else $error("read data not from internal state");
  a_restore_copy: assert property (restore_now |=> s_reg.w[IDX_HORIZONTAL_COUNT] == $past(s_reg.q[IDX_HORIZONTAL_COUNT])) // RL3
    else $error("restore did not copy count");
  a_three_stage: assert property (restore_now && !s_reg.q[IDX_CTRL][CTRL_RLD_SRC_BIT]
      |=> s_reg.w[IDX_SRC] == $past(s_reg.init_src) && s_reg.init_src == $past(s_reg.q[IDX_SRC])) // RL5
    else $error("source stages did not shift");
  a_src_frozen: assert property (stepping && s_reg.w[IDX_ROUTE][2:0] == DATA_ROUTE_FIELD_SRC
      |=> s_reg.w[IDX_SRC] == $past(s_reg.w[IDX_SRC])) // RL10
    else $error("source pointer moved with host source");
  a_drop_fault: assert property (drop_now |=> fault_o && hreadyout_o) // RL23
    else $error("dropped write raised no fault");
  a_stall_wait: assert property (stall_now |=> !hreadyout_o) // RL21
    else $error("full write not stretched");
  a_walk_done: assert property (stepping && lend
      && s_reg.w[IDX_YPOS][11:0] == s_reg.w[IDX_VERTICAL_COUNT][11:0] |=> !busy_o ##1 !busy_o) // RL24
    else $error("walk did not end at last line");
  a_mix_order: assert property (stepping && s_reg.w[IDX_ROUTE][2:0] == DATA_ROUTE_FIELD_MIX
      && !s_reg.w[IDX_CTRL][CTRL_XDEC_BIT] && s_reg.kidx == 6'h0 |-> mix_bit == s_reg.word[0]) // RL22
    else $error("mix bit order wrong");
  a_step_pulse: assert property (stepping |=> step_o && wr_addr_o == $past(s_reg.w[IDX_DST])) // RL6
    else $error("step output mismatch");

  c_restore: cover property (restore_now);
  c_drop: cover property (drop_now);
  c_stall: cover property (stall_now ##[1:8] s_reg.hready);
  c_done: cover property (busy_o ##1 !busy_o);

endmodule : blit_engine

// ### src/blit_host_feed.sv
// host data accumulator: gathers one transfer-width element
// assumes lanes follow the host's aligned writes
`timescale 1ns/1ps
module blit_host_feed
  import blit_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // host side
  input wire logic wr_i,
  input wire logic [3:0] lanes_i,
  input wire logic [31:0] wdata_i,
  input wire logic [1:0] width_i,
  input wire logic flush_i,
  output logic in_ready_o,
  // engine side
  output logic out_valid_o,
  output logic [31:0] out_data_o,
  input wire logic out_ready_i
);

  typedef struct packed {
    logic [31:0] data;
    logic [2:0] cnt;
    logic valid;
  } feed_s;

  feed_s s_reg;
  feed_s s_next;

  always_comb begin
    logic [2:0] nb;
    logic [1:0] pos;
    nb = width_bytes(width_i);
    pos = 2'h0;
    s_next = s_reg;
    if (flush_i || (out_ready_i && s_reg.valid)) begin
      s_next = '0;
    end
    // byte position depends only on lane and width, so cycle order never matters
    if (wr_i && !s_reg.valid && !flush_i) begin
      for (int j = 0; j < 4; j++) begin
        if (lanes_i[j]) begin
          pos = 2'(j) & 2'(nb - 3'h1);
          s_next.data[{pos, 3'b000} +: 8] = wdata_i[j * 8 +: 8];
          s_next.cnt = s_next.cnt + 3'h1;
        end
      end
      if (s_next.cnt >= nb) begin
        s_next.valid = 1'b1; // RL16
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_reg <= '0;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign in_ready_o = !s_reg.valid;
  assign out_valid_o = s_reg.valid;
  assign out_data_o = s_reg.data;

endmodule : blit_host_feed
